// ### core/csmcr_bank.sv
// Module: configuration and subcarrier register bank with the datapath selections it steers
//
// Function
// - Config bit 7 high sends interpolated pixels to digital composite port, else plain.
// - RGB limit clear passes codes; set clamps converter codes to 256..1023.
// - Gaussian filter used when bit 5 clear, bypassed when set.
// - Bit 4 clear clocks composite port by pixel clock, set by processing clock.
// - Bit 3 adds 256 to second composite chroma lying below sync level.
// - Rounding bit set gives extra rounding bits on multipliers 8, 9, 10.
// - Format 00 YCbCr to YPbPr, 01 YCbCr to RGB, 10 RGB to YPbPr.
// - Frequency word bytes 7-0 up to 31-24 at ascending consecutive offsets.
// - Phase offset low byte holds bits 7-0, next offset bits 15-8.
`timescale 1ns/100ps
`default_nettype none

module csmcr_bank
    import csmcr_pkg::*;
#(
    parameter int PIX_BITS = PIX_W,
    parameter logic [9:0] SYNC_LEVEL = SYNC_LEVEL_DEF
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire csmcr_bus_t bus_req,
    output logic [DATA_W-1:0] rd_data,
    // Digital composite sources
    input wire logic [PIX_BITS-1:0] interp_pixel,
    input wire logic [PIX_BITS-1:0] plain_pixel,
    output logic [PIX_BITS-1:0] digital_composite_port,
    output logic composite_clock_select,
    // Gaussian filter path
    input wire logic [PIX_BITS-1:0] gauss_filtered,
    input wire logic [PIX_BITS-1:0] gauss_raw,
    output logic [PIX_BITS-1:0] gauss_out,
    // Second composite chroma
    input wire logic [PIX_BITS-1:0] chroma_in,
    output logic [PIX_BITS-1:0] second_composite_output,
    // RGB converter codes
    input wire csmcr_rgb_t rgb_in,
    output csmcr_rgb_t rgb_out,
    // Colour matrix setup
    output logic extended_rounding,
    output logic matrix_in_rgb,
    output logic matrix_out_rgb,
    // Subcarrier setup
    output logic [31:0] subcarrier_freq_word,
    output logic [15:0] video_phase_offset
);

    // Datapath here is fixed to the 10 bit converter codes
    if (PIX_BITS != PIX_W)
    begin : g_bad_width
        $error("csmcr_bank: pixel width must match converter width");
    end

    // Offset match, used by write and read decode alike
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    csmcr_cfg_t cfg;
    logic [7:0] sc_byte [SC_BYTES];

    // Configuration byte decode
    wire logic cfg_wr = bus_req.wr && hit(bus_req.addr, OFS_CONFIG);
    wire logic cfg_rd = bus_req.rd && hit(bus_req.addr, OFS_CONFIG);

    // Configuration byte, written whole
    always_ff @(posedge core_clk)
    begin
        if (srst)
            cfg <= csmcr_cfg_t'(RST_CONFIG);
        else if (cfg_wr)
            cfg <= csmcr_cfg_t'(bus_req.wdata);
    end

    // Subcarrier bytes, one generated register per offset
    genvar gi;
    for (gi = 0; gi < SC_BYTES; gi++)
    begin : g_sc
        wire logic [7:0] ofs = OFS_FREQ_BYTE0 + 8'(gi);
        wire logic byte_wr = bus_req.wr && hit(bus_req.addr, ofs);
        always_ff @(posedge core_clk)
        begin
            if (srst)
                sc_byte[gi] <= RST_SC_BYTE;
            else if (byte_wr)
                sc_byte[gi] <= bus_req.wdata;
        end
    end

    assign subcarrier_freq_word = {sc_byte[3], sc_byte[2], sc_byte[1], sc_byte[0]};
    assign video_phase_offset = {sc_byte[5], sc_byte[4]};

    ////////////////////////////////////////////////////////////////////////
    // Read port: data stand only in the cycle after the strobe
    logic [7:0] read_mux;
    always_comb
    begin
        if (!bus_req.rd)
            read_mux = RD_IDLE;
        else if (hit(bus_req.addr, OFS_CONFIG))
            read_mux = cfg;
        else if (hit(bus_req.addr, OFS_FREQ_BYTE0))
            read_mux = sc_byte[0];
        else if (hit(bus_req.addr, OFS_FREQ_BYTE1))
            read_mux = sc_byte[1];
        else if (hit(bus_req.addr, OFS_FREQ_BYTE2))
            read_mux = sc_byte[2];
        else if (hit(bus_req.addr, OFS_FREQ_BYTE3))
            read_mux = sc_byte[3];
        else if (hit(bus_req.addr, OFS_PHASE_LOW))
            read_mux = sc_byte[4];
        else if (hit(bus_req.addr, OFS_PHASE_HIGH))
            read_mux = sc_byte[5];
        else
            read_mux = RD_IDLE; // Unmapped offsets read as zero
    end

    // Read data register
    always_ff @(posedge core_clk)
    begin
        if (srst)
            rd_data <= RD_IDLE;
        else
            rd_data <= read_mux;
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath selections
    // composite source
    wire logic [PIX_BITS-1:0] next_dcp = cfg.composite_source_select ? interp_pixel : plain_pixel;
    wire logic [PIX_BITS-1:0] next_gauss = cfg.gaussian_bypass ? gauss_raw : gauss_filtered;
    // chroma below sync gets the offset; saturate rather than wrap
    wire logic chroma_low = chroma_in < SYNC_LEVEL;
    wire logic [PIX_BITS:0] chroma_sum = {1'b0, chroma_in} + {1'b0, CHROMA_OFFSET};
    wire logic [PIX_BITS-1:0] chroma_sat = chroma_sum[PIX_BITS] ? {PIX_BITS{1'b1}} : chroma_sum[PIX_BITS-1:0];
    wire logic [PIX_BITS-1:0] next_chroma = (cfg.chroma_offset_control && chroma_low) ? chroma_sat : chroma_in;
    wire logic next_in_rgb = (cfg.matrix_format == CSMCR_RGB_TO_YPBPR) || (cfg.matrix_format == CSMCR_RGB_TO_RGB);
    // code 11 is RGB to RGB
    wire logic next_out_rgb = (cfg.matrix_format == CSMCR_YCBCR_TO_RGB) || (cfg.matrix_format == CSMCR_RGB_TO_RGB);

    // Sample registers; one cycle of latency on every path keeps them aligned
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            digital_composite_port <= '0;
            gauss_out <= '0;
            second_composite_output <= '0;
        end
        else
        begin
            digital_composite_port <= next_dcp;
            gauss_out <= next_gauss;
            second_composite_output <= next_chroma;
        end
    end

    // Matrix and clock flags, registered from the config byte
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            composite_clock_select <= 1'b0;
            extended_rounding <= 1'b0;
            matrix_in_rgb <= 1'b0;
            matrix_out_rgb <= 1'b0;
        end
        else
        begin
            // clock select to the external clock mux
            composite_clock_select <= cfg.composite_clock_select;
            extended_rounding <= cfg.extended_rounding;
            matrix_in_rgb <= next_in_rgb;
            matrix_out_rgb <= next_out_rgb;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one limiter per RGB channel
    wire logic [PIX_BITS-1:0] rgb_in_ch [3];
    wire logic [PIX_BITS-1:0] rgb_out_ch [3];
    assign rgb_in_ch[0] = rgb_in.r;
    assign rgb_in_ch[1] = rgb_in.g;
    assign rgb_in_ch[2] = rgb_in.b;
    for (gi = 0; gi < 3; gi++)
    begin : g_clamp
        csmcr_clamp #(
            .W(PIX_BITS),
            .LO(RGB_LIMIT_LO),
            .HI(RGB_LIMIT_HI)
        ) csmcr_clamp_inst (
            .core_clk(core_clk),
            .srst(srst),
            .limit_en(cfg.rgb_limit_enable),
            .data_in(rgb_in_ch[gi]),
            .data_out(rgb_out_ch[gi])
        );
    end
    assign rgb_out = {rgb_out_ch[0], rgb_out_ch[1], rgb_out_ch[2]};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Write data fields, named once so the checks read like the rules
    wire logic [7:0] wd = bus_req.wdata;
    wire logic wd_src = wd[BIT_SOURCE_SEL];
    wire logic wd_clk = wd[BIT_CLOCK_SEL];
    wire logic wd_round = wd[BIT_EXT_ROUND];
    wire logic wd_fmt_hi = wd[BIT_FMT_HI];
    wire logic wd_out_rgb = (wd[1:0] == CSMCR_YCBCR_TO_RGB) || (wd[1:0] == CSMCR_RGB_TO_RGB);

    // Sampled srst in the antecedents: the edge that leaves reset still clears the outputs,
    // so it must not be judged against whatever the inputs carry at that moment
    // source check
    chk_dcp_source: assert property (!srst |=>
        digital_composite_port == ($past(cfg.composite_source_select) ? $past(interp_pixel) : $past(plain_pixel)))
        else $error("composite port source wrong");
    chk_source_write: assert property (cfg_wr |=> cfg.composite_source_select == $past(wd_src))
        else $error("source select not stored");
    chk_rgb_floor: assert property ($past(cfg.rgb_limit_enable) |-> rgb_out.r >= RGB_LIMIT_LO &&
        rgb_out.g >= RGB_LIMIT_LO && rgb_out.b >= RGB_LIMIT_LO)
        else $error("rgb code below limit");
    chk_rgb_lift: assert property (!srst && cfg.rgb_limit_enable && rgb_in.r < RGB_LIMIT_LO |=>
        rgb_out.r == RGB_LIMIT_LO)
        else $error("low rgb code not lifted");
    chk_rgb_pass: assert property (!srst && !cfg.rgb_limit_enable |=> rgb_out == $past(rgb_in))
        else $error("rgb code altered while unlimited");
    chk_gauss_path: assert property (!srst |=>
        gauss_out == ($past(cfg.gaussian_bypass) ? $past(gauss_raw) : $past(gauss_filtered)))
        else $error("gaussian path wrong");
    chk_clock_select: assert property (cfg_wr |=> ##1 composite_clock_select == $past(wd_clk, 2))
        else $error("clock select not applied");
    chk_chroma_offset: assert property (cfg.chroma_offset_control && chroma_in < SYNC_LEVEL |=>
        second_composite_output == $past(chroma_in) + CHROMA_OFFSET)
        else $error("chroma offset missing");
    chk_chroma_pass: assert property (!srst && !(cfg.chroma_offset_control && chroma_in < SYNC_LEVEL) |=>
        second_composite_output == $past(chroma_in))
        else $error("chroma altered without offset");
    chk_rounding_flag: assert property (cfg_wr |=> ##1 extended_rounding == $past(wd_round, 2))
        else $error("rounding mode not applied");
    chk_matrix_input: assert property (cfg_wr |=> ##1 matrix_in_rgb == $past(wd_fmt_hi, 2))
        else $error("matrix input format wrong");
    chk_matrix_output: assert property (cfg_wr |=> ##1 matrix_out_rgb == $past(wd_out_rgb, 2))
        else $error("matrix output format wrong");
    chk_freq_low: assert property (bus_req.wr && bus_req.addr == OFS_FREQ_BYTE0 |=>
        subcarrier_freq_word[7:0] == $past(wd))
        else $error("frequency low byte misplaced");
    chk_freq_top: assert property (bus_req.wr && bus_req.addr == OFS_FREQ_BYTE3 |=>
        subcarrier_freq_word[31:24] == $past(wd))
        else $error("frequency top byte misplaced");
    chk_read_freq: assert property (bus_req.rd && bus_req.addr == OFS_FREQ_BYTE3 |=>
        rd_data == $past(subcarrier_freq_word[31:24]))
        else $error("frequency top byte readback wrong");
    chk_phase_low: assert property (bus_req.wr && bus_req.addr == OFS_PHASE_LOW |=>
        video_phase_offset[7:0] == $past(wd))
        else $error("phase low byte misplaced");
    chk_phase_high: assert property (bus_req.wr && bus_req.addr == OFS_PHASE_HIGH |=>
        video_phase_offset[15:8] == $past(wd))
        else $error("phase high byte misplaced");
    // Read timing
    chk_read_config: assert property (cfg_rd |=> rd_data == $past(cfg))
        else $error("config readback wrong");
    // Read data fall back to idle when no read was taken
    chk_read_idle: assert property (!bus_req.rd |=> rd_data == RD_IDLE)
        else $error("read data left standing");

    cov_limit_active: cover property (cfg.rgb_limit_enable && rgb_in.r < RGB_LIMIT_LO);
    cov_chroma_shift: cover property (cfg.chroma_offset_control && chroma_low);
    cov_rgb_format: cover property (cfg_wr ##1 cfg.matrix_format == CSMCR_RGB_TO_RGB);
    cov_write_read: cover property (cfg_wr ##1 cfg_rd);
    cov_phase_write: cover property (bus_req.wr && bus_req.addr == OFS_PHASE_HIGH);

endmodule // csmcr_bank

`default_nettype wire

// ### core/csmcr_clamp.sv
// Module: one RGB channel limiter in front of a converter
`timescale 1ns/100ps
`default_nettype none

module csmcr_clamp
    import csmcr_pkg::*;
#(
    parameter int W = PIX_W,
    parameter logic [W-1:0] LO = RGB_LIMIT_LO,
    parameter logic [W-1:0] HI = RGB_LIMIT_HI
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Control
    input wire logic limit_en,
    // Samples
    input wire logic [W-1:0] data_in,
    output logic [W-1:0] data_out
);

    // Elaboration check on the limit window
    if (LO > HI)
    begin : g_bad_window
        $error("csmcr_clamp: lower limit above upper limit");
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit selection
    wire logic below_lo = data_in < LO;
    wire logic above_hi = data_in > HI;
    wire logic [W-1:0] limited = below_lo ? LO : (above_hi ? HI : data_in);
    wire logic [W-1:0] next_data_out = limit_en ? limited : data_in;

    // Registered so the converter sees a clean code
    always_ff @(posedge core_clk)
    begin
        if (srst)
            data_out <= '0;
        else
            data_out <= next_data_out;
    end

endmodule // csmcr_clamp

`default_nettype wire

// ### inc/csmcr_pkg.sv
// Package: register map, field layout, constants and carriers of the matrix and subcarrier config bank
package csmcr_pkg;

    // Widths of the register port and of the pixel samples
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PIX_W = 10;

    // Register offsets on the control port
    localparam logic [7:0] OFS_CONFIG = 8'h3f;
    localparam logic [7:0] OFS_FREQ_BYTE0 = 8'h40;
    localparam logic [7:0] OFS_FREQ_BYTE1 = 8'h41;
    localparam logic [7:0] OFS_FREQ_BYTE2 = 8'h42;
    localparam logic [7:0] OFS_FREQ_BYTE3 = 8'h43;
    localparam logic [7:0] OFS_PHASE_LOW = 8'h44;
    localparam logic [7:0] OFS_PHASE_HIGH = 8'h45;

    // Subcarrier bytes sit at consecutive offsets from the first frequency byte
    localparam int FREQ_BYTES = 4;
    localparam int PHASE_BYTES = 2;
    localparam int SC_BYTES = FREQ_BYTES + PHASE_BYTES;

    // Field positions inside the configuration byte
    localparam int BIT_SOURCE_SEL = 7;
    localparam int BIT_RGB_LIMIT = 6;
    localparam int BIT_GAUSSIAN_BYPASS = 5;
    localparam int BIT_CLOCK_SEL = 4;
    localparam int BIT_CHROMA_OFS = 3;
    localparam int BIT_EXT_ROUND = 2;
    localparam int BIT_FMT_HI = 1;

    // Reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_SC_BYTE = 8'h00;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // Converter code limits and chroma offset
    localparam logic [9:0] RGB_LIMIT_LO = 10'h100;
    localparam logic [9:0] RGB_LIMIT_HI = 10'h3ff;
    localparam logic [9:0] CHROMA_OFFSET = 10'h100;
    localparam logic [9:0] SYNC_LEVEL_DEF = 10'h00c;
    localparam logic [9:0] PIX_ZERO = 10'h000;

    // Colour matrix input and output format
    typedef enum logic [1:0] {
        CSMCR_YCBCR_TO_YPBPR = 2'h0,
        CSMCR_YCBCR_TO_RGB = 2'h1,
        CSMCR_RGB_TO_YPBPR = 2'h2,
        CSMCR_RGB_TO_RGB = 2'h3
    } csmcr_fmt_t;

    // Configuration byte, bit 7 first
    typedef struct packed {
        logic composite_source_select;
        logic rgb_limit_enable;
        logic gaussian_bypass;
        logic composite_clock_select;
        logic chroma_offset_control;
        logic extended_rounding;
        csmcr_fmt_t matrix_format;
    } csmcr_cfg_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } csmcr_bus_t;

    // One RGB sample triple
    typedef struct packed {
        logic [9:0] r;
        logic [9:0] g;
        logic [9:0] b;
    } csmcr_rgb_t;

endpackage

// ### sim/csmcr_bank_tb.sv
// Testbench: self-checking bench for the matrix and subcarrier config bank
`timescale 1ns/100ps
`default_nettype none

module csmcr_bank_tb
    import csmcr_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic core_clk;
    logic srst;
    csmcr_bus_t bus_req;
    logic [7:0] rd_data;
    logic [9:0] interp_pixel, plain_pixel, gauss_filtered, gauss_raw, chroma_in;
    logic [9:0] digital_composite_port, gauss_out, second_composite_output;
    logic composite_clock_select, extended_rounding, matrix_in_rgb, matrix_out_rgb;
    csmcr_rgb_t rgb_in, rgb_out;
    logic [31:0] subcarrier_freq_word;
    logic [15:0] video_phase_offset;
    int fails;
    int cmp_count;

    csmcr_bank csmcr_bank_inst (
        .core_clk(core_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .interp_pixel(interp_pixel), .plain_pixel(plain_pixel),
        .digital_composite_port(digital_composite_port), .composite_clock_select(composite_clock_select),
        .gauss_filtered(gauss_filtered), .gauss_raw(gauss_raw), .gauss_out(gauss_out),
        .chroma_in(chroma_in), .second_composite_output(second_composite_output),
        .rgb_in(rgb_in), .rgb_out(rgb_out), .extended_rounding(extended_rounding),
        .matrix_in_rgb(matrix_in_rgb), .matrix_out_rgb(matrix_out_rgb),
        .subcarrier_freq_word(subcarrier_freq_word), .video_phase_offset(video_phase_offset)
    );

    // 25 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe; returns at the edge that takes it
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, then fall to zero
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        check("rd_data", {24'h00_0000, rd_data}, {24'h00_0000, exp});
        @(posedge core_clk);
        #1;
        check("rd_data idle", {24'h00_0000, rd_data}, 32'h0000_0000);
    endtask

    // Present one sample set; outputs are looked at one cycle later
    task automatic pix(input logic [9:0] ip, input logic [9:0] pp, input logic [9:0] ch, input csmcr_rgb_t rgb);
        @(posedge core_clk);
        interp_pixel <= ip;
        plain_pixel <= pp;
        gauss_filtered <= ip;
        gauss_raw <= pp;
        chroma_in <= ch;
        rgb_in <= rgb;
        @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic scn_regs();
        // Reset values, readback of every mapped offset, unmapped offsets ignored
        for (int i = 0; i < 7; i++)
            bus_rd(OFS_CONFIG + 8'(i), 8'h00);
        for (int i = 0; i < 7; i++)
            bus_wr(OFS_CONFIG + 8'(i), 8'hA0 + 8'(i));
        for (int i = 0; i < 7; i++)
            bus_rd(OFS_CONFIG + 8'(i), 8'hA0 + 8'(i));
        bus_wr(8'h46, 8'hFF);
        bus_rd(8'h46, 8'h00);
        bus_rd(8'h3e, 8'h00);
        bus_rd(OFS_CONFIG, 8'hA0);
    endtask

    task automatic scn_subcarrier();
        bus_wr(OFS_FREQ_BYTE0, 8'h78);
        bus_wr(OFS_FREQ_BYTE1, 8'h56);
        #1;
        check("freq partial", subcarrier_freq_word[15:0], 32'h0000_5678);
        bus_wr(OFS_FREQ_BYTE2, 8'h34);
        bus_wr(OFS_FREQ_BYTE3, 8'h12);
        bus_wr(OFS_PHASE_LOW, 8'hCD);
        bus_wr(OFS_PHASE_HIGH, 8'hAB);
        #1;
        check("freq word", subcarrier_freq_word, 32'h1234_5678);
        check("phase", {16'h0000, video_phase_offset}, 32'h0000_ABCD);
    endtask

    task automatic scn_select();
        // Source, filter bypass and clock select in both settings
        bus_wr(OFS_CONFIG, 8'hB0);
        pix(10'h2AA, 10'h155, 10'h200, '{10'h200, 10'h200, 10'h200});
        check("dcp interp", digital_composite_port, 32'h0000_02AA);
        check("gauss raw", gauss_out, 32'h0000_0155);
        check("clk sel", composite_clock_select, 32'h0000_0001);
        bus_wr(OFS_CONFIG, 8'h00);
        pix(10'h2AA, 10'h155, 10'h200, '{10'h200, 10'h200, 10'h200});
        check("dcp plain", digital_composite_port, 32'h0000_0155);
        check("gauss filt", gauss_out, 32'h0000_02AA);
        check("clk sel", composite_clock_select, 32'h0000_0000);
    endtask

    task automatic scn_clamp_chroma();
        // Limit off passes low codes; limit on lifts them to 256, keeps the top
        pix(10'h000, 10'h000, 10'h005, '{10'h050, 10'h3FF, 10'h0FF});
        check("rgb pass", rgb_out, {2'b00, 10'h050, 10'h3FF, 10'h0FF});
        check("chroma off", second_composite_output, 32'h0000_0005);
        bus_wr(OFS_CONFIG, 8'h48);
        pix(10'h000, 10'h000, 10'h005, '{10'h050, 10'h3FF, 10'h0FF});
        check("rgb clamp", rgb_out, {2'b00, 10'h100, 10'h3FF, 10'h100});
        check("chroma add", second_composite_output, 32'h0000_0105);
        pix(10'h000, 10'h000, 10'h00C, '{10'h100, 10'h101, 10'h200});
        check("rgb in range", rgb_out, {2'b00, 10'h100, 10'h101, 10'h200});
        check("chroma at sync", second_composite_output, 32'h0000_000C);
    endtask

    task automatic scn_matrix();
        // Every matrix format code once, extra rounding set for codes 00 and 10 only
        for (int f = 0; f < 4; f++)
        begin
            // Rounding bit runs opposite to format bit 0 so a crossed wire cannot hide
            bus_wr(OFS_CONFIG, {5'b00000, ~f[0], f[1:0]});
            pix(10'h000, 10'h000, 10'h200, '{10'h200, 10'h200, 10'h200});
            check("ext round", extended_rounding, {31'h0, ~f[0]});
            check("in rgb", matrix_in_rgb, {31'h0, f[1]});
            check("out rgb", matrix_out_rgb, {31'h0, f[0]});
        end
    endtask

    task automatic scn_rereset();
        // A second reset clears the subcarrier word
        do_reset();
        @(posedge core_clk);
        #1;
        check("freq after reset", subcarrier_freq_word, 32'h0000_0000);
        check("dcp after reset", digital_composite_port, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard: no run is near this long
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        fails = 0;
        cmp_count = 0;
        srst = 1'b1;
        bus_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        interp_pixel = 10'h000;
        plain_pixel = 10'h000;
        gauss_filtered = 10'h000;
        gauss_raw = 10'h000;
        chroma_in = 10'h000;
        rgb_in = '{10'h000, 10'h000, 10'h000};
        do_reset();
        scn_regs();
        scn_subcarrier();
        scn_select();
        scn_clamp_chroma();
        scn_matrix();
        scn_rereset();
        tally_and_finish();
    end
endmodule // csmcr_bank_tb

`default_nettype wire
